// >>> common/mod_cfg.svh
// opcode values, field positions and reset values of the macroinstruction decoder
// assumes: included by bare name from the decoder module only; the package does not include it
`ifndef MOD_CFG_SVH
`define MOD_CFG_SVH

// whole-word opcodes
`define MOD_OP_INT_ENABLE 16'h0400
`define MOD_OP_INT_INHIBIT 16'h0500
`define MOD_OP_PROTECT_SET 16'h0600
`define MOD_OP_PROTECT_CLEAR 16'h0700
`define MOD_OP_MICRO_INT_DEFINE 16'h0b06
`define MOD_OP_BREAKPOINT_CLEAR 16'h0b07
`define MOD_OP_ABSOLUTE_MODE 16'h0b0b
`define MOD_OP_MONITOR_PAGE_MODE 16'h0b0c
`define MOD_OP_PROGRAM_PAGE_MODE 16'h0b0d
`define MOD_OP_LINE_SET_SAMPLE 16'h0b04
`define MOD_OP_POSITION_SAMPLE 16'h0b05

// upper-byte opcode groups
`define MOD_HI_REG_SKIP 8'h00
`define MOD_HI_WORD_INPUT 8'h02
`define MOD_HI_WORD_OUTPUT 8'h03
`define MOD_HI_STORAGE 8'h04
`define MOD_HI_FIELD_SKIP 8'h05
`define MOD_HI_ENHANCED 8'h0b
`define MOD_HI_INT_EXIT 8'h0e
`define MOD_HI_SHIFT 8'h0f

// enhanced register-reference low digit for page registers
`define MOD_LO_PAGE_READ 4'h3
`define MOD_LO_PAGE_WRITE 4'h4

// address mode register values
`define MOD_ADM_ABSOLUTE 2'h0
`define MOD_ADM_MONITOR 2'h2
`define MOD_ADM_PROGRAM 2'h3
`define MOD_ADM_RESET 2'h0

// field positions within the low byte
`define MOD_REG_SKIP_SEL_MSB 6
`define MOD_REG_SKIP_SEL_LSB 4
`define MOD_REG_SKIP_DEC_BIT 3
`define MOD_FIELD_SKIP_NZ_BIT 7
`define MOD_SHIFT_LEFT_BIT 7
`define MOD_SHIFT_TGT_MSB 6
`define MOD_SHIFT_TGT_LSB 5
`define MOD_SHIFT_CNT_MSB 4

`endif

// >>> common/mod_pkg.sv
// types shared by the macroinstruction decoder modules
// assumes: no include of mod_cfg.svh; the enum codes are written as literals here
package mod_pkg;

    // enhanced register selector, r = 1, 2, 3, 4, Q, A, I -> 1..7
    typedef enum logic [2:0] {
        MOD_R_NONE = 3'b000,
        MOD_R_1 = 3'b001,
        MOD_R_2 = 3'b010,
        MOD_R_3 = 3'b011,
        MOD_R_4 = 3'b100,
        MOD_R_Q = 3'b101,
        MOD_R_A = 3'b110,
        MOD_R_I = 3'b111
    } mod_reg_sel_type;

    // register test variant
    typedef enum logic [1:0] {
        MOD_T_ZERO = 2'b00,
        MOD_T_NONZERO = 2'b01,
        MOD_T_POSITIVE = 2'b10,
        MOD_T_NEGATIVE = 2'b11
    } mod_test_type;

    // shift target
    typedef enum logic [1:0] {
        MOD_S_NONE = 2'b00,
        MOD_S_ACC = 2'b01,
        MOD_S_AUX = 2'b10,
        MOD_S_LONG = 2'b11
    } mod_shift_tgt_type;

    // decoder sequencing
    typedef enum logic [0:0] {
        MOD_ST_FIRST = 1'b0,
        MOD_ST_SECOND = 1'b1
    } mod_state_type;

endpackage

// >>> design/mod_decode.sv
// macroinstruction decoder and dispatcher: skips, repeat, shifts, word i/o,
// interrupt, program protect and page control
// assumes: fetch stage presents one word per i_instr_valid cycle; register
// values on i_reg_* are current; all results appear one cycle later
//
// Notes on behaviour
// - word 0400 turns interrupt acceptance on
// - word 0500 blocks interrupt acceptance until enabled again
// - upper byte 0E exits interrupt state; low byte is an operand
// - word 0B06 defines a micro-interrupt
// - word 0B07 clears a pending breakpoint interrupt
// - word 0600 turns program protect on
// - word 0700 turns program protect off
// - word 0B0B loads 0 into the address mode register (absolute)
// - word 0B0C loads 2 into the address mode register (monitor paging)
// - word 0B0D loads 3 into the address mode register (program paging)
// - 0Bx3 reads, 0Bx4 writes a page register; middle digit selects it
// - register selector: 1, 2, 3, 4, Q, A, I coded as one to seven
// - upper byte 0F right shifts of A, Q or QA replicate the sign
// - left shifts of A or Q rotate end-around
// - long shifts treat QA as one register: sign-extend right, rotate left
// - upper byte 02 moves an input word into A
// - upper byte 03 sends A to an output device
// - word 0B04 sets or samples output or input lines
// - word 0B05 samples position and status
// - upper byte 00 skips on selected register zero, non-zero, positive, negative
// - decrement-and-repeat decrements the register, repeats while it stays positive and non-zero
// - field reference 05 skips when the field is zero, or not zero
// - 04 with non-zero field is multi-word storage; second word gives operation
`timescale 1ns/10ps
`default_nettype none
`include "mod_cfg.svh"
module mod_decode
    import mod_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // instruction from fetch
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    // operands from the core
    input wire logic [15:0] i_reg_1,
    input wire logic [15:0] i_reg_2,
    input wire logic [15:0] i_reg_3,
    input wire logic [15:0] i_reg_4,
    input wire logic [15:0] i_reg_q,
    input wire logic [15:0] i_reg_a,
    input wire logic [15:0] i_reg_i,
    input wire logic [15:0] i_field_value,
    input wire logic [15:0] i_io_data_in,
    // machine state
    output logic o_int_enabled,
    output logic o_protect,
    output logic [1:0] o_address_mode_register,
    // interrupt strobes
    output logic o_int_exit,
    output logic [7:0] o_exit_operand,
    output logic o_micro_int_define,
    output logic o_breakpoint_clear,
    // page registers
    output logic o_page_read,
    output logic o_page_write,
    output logic [3:0] o_page_sel,
    // input/output
    output logic o_io_input,
    output logic o_io_output,
    output logic [7:0] o_io_addr,
    output logic [15:0] o_io_data_out,
    output logic o_line_set_sample,
    output logic o_position_sample,
    // sequencing and writeback
    output logic o_skip,
    output logic o_repeat,
    output logic o_reg_write,
    output mod_reg_sel_type o_reg_wsel,
    output logic [15:0] o_reg_wdata,
    output logic o_a_write,
    output logic [15:0] o_a_data,
    output logic o_q_write,
    output logic [15:0] o_q_data,
    // multi-word storage instruction
    output logic o_storage_op,
    output logic [15:0] o_storage_word1,
    output logic [15:0] o_storage_word2,
    // nothing matched
    output logic o_unknown
);

    // ---------------------------------------------------------------
    // field extraction
    // ---------------------------------------------------------------
    logic [7:0] hi;
    logic [7:0] lo;
    mod_reg_sel_type skip_sel;
    mod_test_type skip_test;
    logic [15:0] sel_value;
    logic [15:0] dec_value;
    logic reg_hit;
    logic field_hit;
    mod_shift_tgt_type shift_tgt;
    logic [15:0] shift_acc;
    logic [15:0] shift_aux;
    logic take_first;
    logic take_second;
    mod_state_type state;
    logic [15:0] word1;

    assign hi = i_instr[15:8];
    assign lo = i_instr[7:0];
    assign skip_sel = mod_reg_sel_type'(lo[`MOD_REG_SKIP_SEL_MSB:`MOD_REG_SKIP_SEL_LSB]);
    assign skip_test = mod_test_type'(lo[1:0]);
    assign shift_tgt = mod_shift_tgt_type'(lo[`MOD_SHIFT_TGT_MSB:`MOD_SHIFT_TGT_LSB]);
    assign take_first = i_instr_valid && (state == MOD_ST_FIRST);
    assign take_second = i_instr_valid && (state == MOD_ST_SECOND);
    assign dec_value = sel_value - 16'h0001;

    // register operand by selector code
    always_comb begin
        case (skip_sel)
            MOD_R_1: sel_value = i_reg_1;
            MOD_R_2: sel_value = i_reg_2;
            MOD_R_3: sel_value = i_reg_3;
            MOD_R_4: sel_value = i_reg_4;
            MOD_R_Q: sel_value = i_reg_q;
            MOD_R_A: sel_value = i_reg_a;
            MOD_R_I: sel_value = i_reg_i;
            default: sel_value = 16'h0000;
        endcase
    end

    mod_reg_test u_reg_test (
        .i_value(sel_value),
        .i_test(skip_test),
        .o_hit(reg_hit)
    );

    mod_reg_test u_field_test (
        .i_value(i_field_value),
        .i_test(lo[`MOD_FIELD_SKIP_NZ_BIT] ? MOD_T_NONZERO : MOD_T_ZERO),
        .o_hit(field_hit)
    );

    mod_shifter u_shifter (
        .i_acc(i_reg_a),
        .i_aux(i_reg_q),
        .i_tgt(shift_tgt),
        .i_left(lo[`MOD_SHIFT_LEFT_BIT]),
        .i_count(lo[`MOD_SHIFT_CNT_MSB:0]),
        .o_acc(shift_acc),
        .o_aux(shift_aux)
    );

    // ---------------------------------------------------------------
    // class decode of a first word
    // ---------------------------------------------------------------
    logic is_int_enable;
    logic is_int_inhibit;
    logic is_protect_set;
    logic is_protect_clear;
    logic is_storage;
    logic is_field_skip;
    logic is_reg_skip;
    logic is_dec_repeat;
    logic is_shift;
    logic is_page_read;
    logic is_page_write;
    logic is_known;

    assign is_int_enable = (i_instr == `MOD_OP_INT_ENABLE);
    assign is_int_inhibit = (i_instr == `MOD_OP_INT_INHIBIT);
    assign is_protect_set = (i_instr == `MOD_OP_PROTECT_SET);
    assign is_protect_clear = (i_instr == `MOD_OP_PROTECT_CLEAR);
    assign is_storage = (hi == `MOD_HI_STORAGE) && (lo != 8'h00);
    assign is_field_skip = (hi == `MOD_HI_FIELD_SKIP) && (lo != 8'h00);
    assign is_reg_skip = (hi == `MOD_HI_REG_SKIP) && (skip_sel != MOD_R_NONE)
        && !lo[7] && !lo[`MOD_REG_SKIP_DEC_BIT];
    assign is_dec_repeat = (hi == `MOD_HI_REG_SKIP) && (skip_sel != MOD_R_NONE)
        && !lo[7] && lo[`MOD_REG_SKIP_DEC_BIT];
    assign is_shift = (hi == `MOD_HI_SHIFT) && (shift_tgt != MOD_S_NONE);
    assign is_page_read = (hi == `MOD_HI_ENHANCED) && (lo[7:4] != 4'h0)
        && (lo[3:0] == `MOD_LO_PAGE_READ);
    assign is_page_write = (hi == `MOD_HI_ENHANCED) && (lo[7:4] != 4'h0)
        && (lo[3:0] == `MOD_LO_PAGE_WRITE);
    assign is_known = is_int_enable || is_int_inhibit || is_protect_set
        || is_protect_clear || is_storage || is_field_skip || is_reg_skip
        || is_dec_repeat || is_shift || is_page_read || is_page_write
        || (hi == `MOD_HI_INT_EXIT) || (hi == `MOD_HI_WORD_INPUT)
        || (hi == `MOD_HI_WORD_OUTPUT)
        || (i_instr == `MOD_OP_MICRO_INT_DEFINE)
        || (i_instr == `MOD_OP_BREAKPOINT_CLEAR)
        || (i_instr == `MOD_OP_ABSOLUTE_MODE)
        || (i_instr == `MOD_OP_MONITOR_PAGE_MODE)
        || (i_instr == `MOD_OP_PROGRAM_PAGE_MODE)
        || (i_instr == `MOD_OP_LINE_SET_SAMPLE)
        || (i_instr == `MOD_OP_POSITION_SAMPLE);

    // ---------------------------------------------------------------
    // sequencing for multi-word storage instructions
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= MOD_ST_FIRST;
            word1 <= 16'h0000;
        end else begin
            case (state)
                MOD_ST_FIRST: begin
                    if (take_first && is_storage) begin
                        state <= MOD_ST_SECOND;
                        word1 <= i_instr;
                    end
                end
                MOD_ST_SECOND: begin
                    if (take_second) begin
                        state <= MOD_ST_FIRST;
                    end
                end
                default: state <= MOD_ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_storage_op <= 1'b0;
            o_storage_word1 <= 16'h0000;
            o_storage_word2 <= 16'h0000;
        end else begin
            o_storage_op <= take_second;
            if (take_second) begin
                o_storage_word1 <= word1;
                o_storage_word2 <= i_instr;
            end
        end
    end

    // ---------------------------------------------------------------
    // machine state: interrupt acceptance, protect, address mode
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_enabled <= 1'b0;
        end else if (take_first && is_int_enable) begin
            o_int_enabled <= 1'b1;
        end else if (take_first && is_int_inhibit) begin
            o_int_enabled <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_protect <= 1'b0;
        end else if (take_first && is_protect_set) begin
            o_protect <= 1'b1;
        end else if (take_first && is_protect_clear) begin
            o_protect <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_address_mode_register <= `MOD_ADM_RESET;
        end else if (take_first) begin
            case (i_instr)
                `MOD_OP_ABSOLUTE_MODE: o_address_mode_register <= `MOD_ADM_ABSOLUTE;
                `MOD_OP_MONITOR_PAGE_MODE: o_address_mode_register <= `MOD_ADM_MONITOR;
                `MOD_OP_PROGRAM_PAGE_MODE: o_address_mode_register <= `MOD_ADM_PROGRAM;
                default: o_address_mode_register <= o_address_mode_register;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // one-cycle strobes and their operands
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_int_exit <= 1'b0;
            o_exit_operand <= 8'h00;
            o_micro_int_define <= 1'b0;
            o_breakpoint_clear <= 1'b0;
            o_page_read <= 1'b0;
            o_page_write <= 1'b0;
            o_page_sel <= 4'h0;
            o_line_set_sample <= 1'b0;
            o_position_sample <= 1'b0;
            o_unknown <= 1'b0;
        end else begin
            o_int_exit <= take_first && (hi == `MOD_HI_INT_EXIT);
            o_micro_int_define <= take_first && (i_instr == `MOD_OP_MICRO_INT_DEFINE);
            o_breakpoint_clear <= take_first && (i_instr == `MOD_OP_BREAKPOINT_CLEAR);
            o_page_read <= take_first && is_page_read;
            o_page_write <= take_first && is_page_write;
            o_line_set_sample <= take_first && (i_instr == `MOD_OP_LINE_SET_SAMPLE);
            o_position_sample <= take_first && (i_instr == `MOD_OP_POSITION_SAMPLE);
            o_unknown <= take_first && !is_known;
            if (take_first && (hi == `MOD_HI_INT_EXIT)) begin
                o_exit_operand <= lo;
            end
            if (take_first && (is_page_read || is_page_write)) begin
                o_page_sel <= lo[7:4];
            end
        end
    end

    // ---------------------------------------------------------------
    // word input/output
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_io_input <= 1'b0;
            o_io_output <= 1'b0;
            o_io_addr <= 8'h00;
            o_io_data_out <= 16'h0000;
        end else begin
            o_io_input <= take_first && (hi == `MOD_HI_WORD_INPUT);
            o_io_output <= take_first && (hi == `MOD_HI_WORD_OUTPUT);
            if (take_first && ((hi == `MOD_HI_WORD_INPUT) || (hi == `MOD_HI_WORD_OUTPUT))) begin
                o_io_addr <= lo;
            end
            if (take_first && (hi == `MOD_HI_WORD_OUTPUT)) begin
                o_io_data_out <= i_reg_a;
            end
        end
    end

    // ---------------------------------------------------------------
    // A and Q writeback: shifts and word input
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_a_write <= 1'b0;
            o_a_data <= 16'h0000;
            o_q_write <= 1'b0;
            o_q_data <= 16'h0000;
        end else begin
            o_a_write <= take_first && ((hi == `MOD_HI_WORD_INPUT)
                || (is_shift && (shift_tgt != MOD_S_AUX)));
            o_q_write <= take_first && is_shift && (shift_tgt != MOD_S_ACC);
            if (take_first && (hi == `MOD_HI_WORD_INPUT)) begin
                o_a_data <= i_io_data_in;
            end else if (take_first && is_shift) begin
                o_a_data <= shift_acc;
            end
            if (take_first && is_shift) begin
                o_q_data <= shift_aux;
            end
        end
    end

    // ---------------------------------------------------------------
    // skips and decrement-and-repeat
    // ---------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_skip <= 1'b0;
            o_repeat <= 1'b0;
            o_reg_write <= 1'b0;
            o_reg_wsel <= MOD_R_NONE;
            o_reg_wdata <= 16'h0000;
        end else begin
            o_skip <= take_first && ((is_reg_skip && reg_hit)
                || (is_field_skip && field_hit));
            o_reg_write <= take_first && is_dec_repeat;
            // repeat while the decremented value stays positive and non-zero
            o_repeat <= take_first && is_dec_repeat && !dec_value[15]
                && (dec_value != 16'h0000);
            if (take_first && is_dec_repeat) begin
                o_reg_wsel <= skip_sel;
                o_reg_wdata <= dec_value;
            end
        end
    end

endmodule
`default_nettype wire

// >>> design/mod_reg_test.sv
// one-word test: zero, non-zero, positive or negative
// assumes: ones-complement style sign in bit 15, +0 is all zeros
`timescale 1ns/10ps
`default_nettype none
module mod_reg_test
    import mod_pkg::*;
(
    // operand
    input wire logic [15:0] i_value,
    input wire mod_test_type i_test,
    // result
    output logic o_hit
);

    always_comb begin
        case (i_test)
            MOD_T_ZERO: o_hit = (i_value == 16'h0000);
            MOD_T_NONZERO: o_hit = (i_value != 16'h0000);
            MOD_T_POSITIVE: o_hit = ~i_value[15];
            MOD_T_NEGATIVE: o_hit = i_value[15];
            default: o_hit = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// >>> design/mod_shifter.sv
// shifter for A, Q and the joined QA pair (Q high, A low)
// assumes: purely combinational, results registered by the caller
`timescale 1ns/10ps
`default_nettype none
module mod_shifter
    import mod_pkg::*;
(
    // operands
    input wire logic [15:0] i_acc,
    input wire logic [15:0] i_aux,
    input wire mod_shift_tgt_type i_tgt,
    input wire logic i_left,
    input wire logic [4:0] i_count,
    // results
    output logic [15:0] o_acc,
    output logic [15:0] o_aux
);

    logic [31:0] long_in;
    logic [31:0] long_right;
    logic [31:0] long_left;
    logic [63:0] long_twice;
    logic [31:0] acc_twice;
    logic [31:0] aux_twice;
    logic [15:0] acc_right;
    logic [15:0] aux_right;
    logic [15:0] acc_left;
    logic [15:0] aux_left;

    assign long_in = {i_aux, i_acc};
    // sign replicated into vacated high bits
    assign acc_right = 16'($signed(i_acc) >>> i_count);
    assign aux_right = 16'($signed(i_aux) >>> i_count);
    assign long_right = 32'($signed(long_in) >>> i_count);
    // end-around: bits leaving the top re-enter at the bottom
    assign acc_twice = {i_acc, i_acc} << i_count[3:0];
    assign aux_twice = {i_aux, i_aux} << i_count[3:0];
    assign long_twice = {long_in, long_in} << i_count;
    assign acc_left = acc_twice[31:16];
    assign aux_left = aux_twice[31:16];
    assign long_left = long_twice[63:32];

    always_comb begin
        o_acc = i_acc;
        o_aux = i_aux;
        case (i_tgt)
            MOD_S_ACC: o_acc = i_left ? acc_left : acc_right;
            MOD_S_AUX: o_aux = i_left ? aux_left : aux_right;
            MOD_S_LONG: begin
                o_acc = i_left ? long_left[15:0] : long_right[15:0];
                o_aux = i_left ? long_left[31:16] : long_right[31:16];
            end
            default: begin
                o_acc = i_acc;
                o_aux = i_aux;
            end
        endcase
    end

endmodule
`default_nettype wire

// >>> dv/mod_decode_assertions.sv
// checker on the decoder top-level ports
// assumes: bound to mod_decode, single clock domain
`timescale 1ns/10ps
`default_nettype none
module mod_decode_assertions (
    // watched ports
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_reg_a,
    input wire logic o_int_enabled,
    input wire logic o_protect,
    input wire logic [1:0] o_address_mode_register,
    input wire logic o_int_exit,
    input wire logic [7:0] o_exit_operand,
    input wire logic o_micro_int_define,
    input wire logic o_io_output,
    input wire logic [15:0] o_io_data_out,
    input wire logic o_storage_op,
    input wire logic [15:0] o_storage_word2
);
default clocking @(posedge i_ref_clk); endclocking
default disable iff (i_rst);
// second word of a storage pair expected
logic sec;
logic fv;
assign fv = i_instr_valid && !sec;
always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
        sec <= 1'b0;
    end else if (i_instr_valid) begin
        sec <= fv && i_instr[15:8] == 8'h04 && i_instr[7:0] != 8'h00;
    end
end
property p_en; fv && i_instr == 16'h0400 |=> o_int_enabled; endproperty
a_en: assert property (p_en) else $error("enable missed");
property p_inh; fv && i_instr == 16'h0500 |=> !o_int_enabled; endproperty
a_inh: assert property (p_inh) else $error("inhibit missed");
property p_exit;
    fv && i_instr[15:8] == 8'h0e |=> o_int_exit && o_exit_operand == $past(i_instr[7:0]);
endproperty
a_exit: assert property (p_exit) else $error("exit wrong");
property p_mdef; fv && i_instr == 16'h0b06 |=> o_micro_int_define; endproperty
a_mdef: assert property (p_mdef) else $error("define missed");
property p_prot; fv && i_instr == 16'h0600 |=> o_protect; endproperty
a_prot: assert property (p_prot) else $error("protect missed");
property p_mode; fv && i_instr == 16'h0b0c |=> o_address_mode_register == 2'h2; endproperty
a_mode: assert property (p_mode) else $error("mode wrong");
property p_out; fv && i_instr[15:8] == 8'h03 |=> o_io_output && o_io_data_out == $past(i_reg_a); endproperty
a_out: assert property (p_out) else $error("output wrong");
property p_stor;
    fv && i_instr[15:8] == 8'h04 && i_instr[7:0] != 8'h00 ##1 i_instr_valid
        |=> o_storage_op && o_storage_word2 == $past(i_instr);
endproperty
a_stor: assert property (p_stor) else $error("storage wrong");
endmodule
bind mod_decode mod_decode_assertions chk_u (.i_ref_clk, .i_rst, .i_instr_valid, .i_instr,
    .i_reg_a, .o_int_enabled, .o_protect, .o_address_mode_register, .o_int_exit,
    .o_exit_operand, .o_micro_int_define, .o_io_output, .o_io_data_out, .o_storage_op,
    .o_storage_word2);
`default_nettype wire

// >>> dv/mod_decode_tb.sv
// self-checking bench for the macroinstruction decoder
// assumes: mod_cfg.svh, mod_pkg and the dv modules compiled first
`timescale 1ns/10ps
`default_nettype none
module mod_decode_tb;
logic i_ref_clk = 1'b0;
logic i_rst = 1'b1;
logic v, vd = 1'b0;
logic [15:0] w, fld = 16'h0000, din = 16'h0000, s, ea = 16'h0000, eq = 16'h0000;
logic [15:0] r [1:7] = '{7{16'h0000}};
logic [31:0] rs = 32'hda30b829;
logic [43:0] q [$];
logic sp, rp, aw, qw, un, so, io, ex, en = 0, pr = 0, sec = 0;
logic [1:0] md = 2'h0;
logic o_int_enabled, o_protect, o_int_exit, o_io_output, o_skip, o_repeat;
logic o_a_write, o_q_write, o_storage_op, o_unknown;
logic [1:0] o_address_mode_register;
logic [15:0] o_a_data, o_q_data;
int err_count = 0, checked = 0, cyc = 0;
localparam logic [15:0] TBL [27] = '{16'h0400, 16'h0500, 16'h0400, 16'h0600, 16'h0700,
    16'h0b0c, 16'h0b0d, 16'h0b0b, 16'h0b0c, 16'h0e5a, 16'h0b06, 16'h0b07, 16'h0b04,
    16'h0b05, 16'h0b13, 16'h0b24, 16'h0203, 16'h0311, 16'h0412, 16'h0f23, 16'h0500,
    16'h0405, 16'h0400, 16'h0600, 16'h0000, 16'h0088, 16'h0500};
mod_fetch_model fetch_u (.i_ref_clk, .o_instr_valid(v), .o_instr(w));
mod_decode dut_u (.i_ref_clk, .i_rst, .i_instr_valid(v), .i_instr(w), .i_reg_1(r[1]),
    .i_reg_2(r[2]), .i_reg_3(r[3]), .i_reg_4(r[4]), .i_reg_q(r[5]), .i_reg_a(r[6]),
    .i_reg_i(r[7]), .i_field_value(fld), .i_io_data_in(din), .o_int_enabled, .o_protect,
    .o_address_mode_register, .o_int_exit, .o_exit_operand(), .o_micro_int_define(),
    .o_breakpoint_clear(), .o_page_read(), .o_page_write(), .o_page_sel(), .o_io_input(),
    .o_io_output, .o_io_addr(), .o_io_data_out(), .o_line_set_sample(),
    .o_position_sample(), .o_skip, .o_repeat, .o_reg_write(), .o_reg_wsel(),
    .o_reg_wdata(), .o_a_write, .o_a_data, .o_q_write, .o_q_data, .o_storage_op,
    .o_storage_word1(), .o_storage_word2(), .o_unknown);
function automatic logic [15:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[15:0];
endfunction
function automatic logic [43:0] key();
    return {o_skip, o_repeat, o_a_write, o_q_write, o_unknown, o_storage_op, o_io_output,
        o_int_exit, o_int_enabled, o_protect, o_address_mode_register, o_a_data, o_q_data};
endfunction
task automatic check(input logic [43:0] got, input logic [43:0] exp);
    checked++;
    if (got !== exp) begin
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic end_sim();
    $display("checks=%0d errors=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
// send one word with fresh operands and note the expected outcome
task automatic op(input logic [15:0] x);
    logic [15:0] nr [1:7];
    logic [15:0] nf, nd, t;
    logic [31:0] l;
    logic [4:0] n;
    for (int k = 1; k < 8; k++) nr[k] = rnd();
    nf = rnd();
    nd = rnd();
    if (nf[3]) nf = 16'h0000;
    fetch_u.put(x, 1'b1);
    for (int k = 1; k < 8; k++) r[k] <= nr[k];
    fld <= nf;
    din <= nd;
    {sp, rp, aw, qw, un, so, io, ex} = 8'h00;
    n = x[4:0];
    t = nr[x[6:4] == 3'h0 ? 3'h1 : x[6:4]];
    l = {nr[5], nr[6]};
    if (sec) begin
        so = 1;
        sec = 0;
    end else case (x[15:8])
        8'h00: if (x[6:4] == 3'h0 || x[7]) un = 1;
            else if (x[3]) begin t = t - 16'h0001; rp = !t[15] && t != 0; end
            else sp = x[1] ? x[0] ^ !t[15] : x[0] ^ (t == 0);
        8'h02: begin aw = 1; ea = nd; end
        8'h03: io = 1;
        8'h04: if (x[7:0] == 8'h00) en = 1; else sec = 1;
        8'h05: if (x[7:0] == 8'h00) en = 0; else sp = x[7] ^ (nf == 0);
        8'h06, 8'h07: pr = !x[8];
        8'h0b: if (x[7:0] == 8'h0b) md = 2'h0; else if (x[7:1] == 7'h06) md = {1'b1, x[0]};
        8'h0e: ex = 1;
        8'h0f: case (x[7:5])
            3'b001: begin aw = 1; ea = $signed(nr[6]) >>> n; eq = nr[5]; end
            3'b010: begin qw = 1; eq = $signed(nr[5]) >>> n; ea = nr[6]; end
            3'b101: begin aw = 1; ea = nr[6] << n[3:0] | nr[6] >> (16 - n[3:0]); eq = nr[5]; end
            3'b110: begin qw = 1; eq = nr[5] << n[3:0] | nr[5] >> (16 - n[3:0]); ea = nr[6]; end
            3'b011, 3'b111: begin
                if (x[7]) l = (l << n) | (l >> (6'd32 - n));
                else l = $signed(l) >>> n;
                {aw, qw, eq, ea} = {2'b11, l};
            end
            default: un = 1;
        endcase
        default: un = 1;
    endcase
    q.push_back({sp, rp, aw, qw, un, so, io, ex, en, pr, md, ea, eq});
endtask
always #2 i_ref_clk = ~i_ref_clk;
always @(posedge i_ref_clk) begin
    vd <= v && !i_rst;
    cyc++;
    if (cyc > 2000) begin
        err_count++;
        end_sim();
    end
end
always @(negedge i_ref_clk) begin
    if (vd) check(key(), q.pop_front());
end
initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    check(key(), 44'h0);
    foreach (TBL[k]) op(TBL[k]);
    repeat (400) begin
        s = rnd();
        case (s[1:0])
            2'd0: op({8'h0f, s[15:8]});
            2'd1: op({9'h000, s[6:3], 1'b0, s[9:8]});
            2'd2: op({8'h05, s[15:8]});
            default: op({8'h02, s[15:8]});
        endcase
    end
    fetch_u.put(16'h0000, 1'b0);
    repeat (3) @(posedge i_ref_clk);
    end_sim();
end
endmodule
`default_nettype wire

// >>> dv/mod_fetch_model.sv
// fetch stage model: one word per call, bus scrambled when idle
// assumes: caller steps it once per clock
`timescale 1ns/10ps
`default_nettype none
module mod_fetch_model (
    // clock
    input wire logic i_ref_clk,
    // instruction out
    output logic o_instr_valid,
    output logic [15:0] o_instr
);
initial begin
    o_instr_valid = 1'b0;
    o_instr = 16'h0000;
end
task automatic put(input logic [15:0] w, input logic v);
    @(posedge i_ref_clk);
    o_instr_valid <= v;
    o_instr <= v ? w : ~o_instr;
endtask
endmodule
`default_nettype wire
